// *** common/vcozd_regs.svh ***
`ifndef VCOZD_REGS_SVH
`define VCOZD_REGS_SVH

// Register indices; the byte address of each register is four times its index.
`define VCOZD_IDX_CALCTL 10'h018
`define VCOZD_IDX_ZDCTL 10'h01e
`define VCOZD_IDX_STATUS 10'h01f
`define VCOZD_IDX_VCODIV 10'h1e0
`define VCOZD_IDX_UPDATE 10'h232
`define VCOZD_IDX_RDIV 10'h011
`define VCOZD_IDX_ZDDLY 10'h0f0

// Calibration control fields.
`define VCOZD_CAL_START_BIT 0
`define VCOZD_CAL_DIV_LSB 1
`define VCOZD_CAL_DIV_MSB 2

// Zero delay control fields.
`define VCOZD_ZD_MODE_LSB 1
`define VCOZD_ZD_MODE_MSB 2
`define VCOZD_ZD_FBSEL_LSB 3
`define VCOZD_ZD_FBSEL_MSB 4

// Status and threshold fields.
`define VCOZD_THR_EXT_BIT 0
`define VCOZD_MON_FLAG_LSB 1
`define VCOZD_MON_FLAG_MSB 3
`define VCOZD_CAL_DONE_BIT 6

// Update strobe field.
`define VCOZD_UPDATE_BIT 0

// Reset values.
`define VCOZD_RST_CALCTL 3'h0
`define VCOZD_RST_ZDCTL 4'h0
`define VCOZD_RST_VCODIV 3'h0
`define VCOZD_RST_RDIV 14'h0001
`define VCOZD_RST_ZDDLY 10'h000

// Timing counts.
`define VCOZD_CAL_CYCLES 13'h1130
`define VCOZD_MON_WINDOW 10'h3ff
`define VCOZD_THR_NORMAL 8'h10
`define VCOZD_THR_EXTENDED 8'h04
`define VCOZD_THR_VCO 8'h10

`endif

// *** common/vcozd_pkg.sv ***
package vcozd_pkg;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_SYNC,
    CAL_TUNE,
    CAL_RELEASE,
    CAL_CLOSE
  } vcozd_cal_state_t;

  typedef enum logic [1:0] {
    ZD_OFF = 2'h0,
    ZD_INTERNAL = 2'h1,
    ZD_RESERVED = 2'h2,
    ZD_EXTERNAL = 2'h3
  } vcozd_zd_mode_t;

endpackage

// *** logic/vcozd_cal_clk.sv ***
`timescale 1ns/1ps
`include "vcozd_regs.svh"

module vcozd_cal_clk (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic pll_reference_input, // Reference input, sampled.
  input wire logic [13:0] rDivide, // R divider value.
  input wire logic [1:0] calDivSel, // Calibration divider select.
  input wire logic run, // Counts only while high.
  output logic calTick // One pulse per calibration clock.
);

  logic refPrev;
  logic [13:0] rCount;
  logic [3:0] calCount;
  wire refRise = pll_reference_input & ~refPrev;
  wire [13:0] rLast = (rDivide == 14'h0000) ? 14'h0000 : rDivide - 14'h0001;
  wire [3:0] calLast = 4'((5'h02 << calDivSel) - 5'h01);
  wire pfdTick = refRise && (rCount == rLast);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refPrev <= 1'b0;
      rCount <= 14'h0000;
      calCount <= 4'h0;
      calTick <= 1'b0;
    end else begin
      refPrev <= pll_reference_input;
      calTick <= 1'b0;
      if (!run) begin
        rCount <= 14'h0000;
        calCount <= 4'h0;
      end else if (refRise) begin
        rCount <= pfdTick ? 14'h0000 : rCount + 14'h0001;
        if (pfdTick) begin
          calCount <= (calCount == calLast) ? 4'h0 : calCount + 4'h1;
          calTick <= (calCount == calLast);
        end
      end
    end
  end

endmodule

// *** logic/vcozd_top.sv ***
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "vcozd_regs.svh"

// Summary of operation
// - Three monitors flag reference one, reference two or VCO below threshold.
// - Reference monitors use normal or extended threshold chosen by a register bit.
// - Calibration runs from divided reference clock; needs reference present.
// - Power-up auto-load request starts calibration; it finishes only with reference.
// - First calibration: set start bit, then update strobe starts it.
// - Read-only done bit reads one once calibration has finished.
// - Start asserts output sync, tunes, releases sync, then closes loop.
// - Sync release adds no hold-off for PLL settling.
// - Calibration clock is reference over R over the selected divider.
// - Calibration lasts 4400 calibration clock cycles.
// - No calibration starts by itself when PLL settings change.
// - Zero delay mode 01 feeds a channel divider back to N divider.
// - Feedback select picks channel divider 0 to 3.
// - Zero delay offers programmable R-path and N-path delays.
// - Zero delay mode 11 feeds back through external clock input.
module vcozd_top (
  input wire logic clock, // System clock, 100 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB ready in.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB ready out.
  output logic hresp, // AHB response.
  input wire logic pllReferenceInput, // Reference clock, sampled.
  input wire logic pllReferenceInput2, // Second reference, sampled.
  input wire logic vcoDivided, // Divided VCO for monitoring.
  input wire logic autoLoadCal, // Nonvolatile auto-load done request.
  output logic syncOutputs, // Holds distribution outputs in sync.
  output logic vcoTuning, // Calibration engine tunes the VCO.
  output logic loopClosed, // PLL loop closed.
  output logic [2:0] monitorLow, // Reference one, two and VCO low flags.
  output logic [1:0] feedbackSourceSelector, // Channel divider feeding back.
  output logic [1:0] nDividerInputSelector, // N divider input source.
  output logic [2:0] vcoDividerSel, // VCO divider setting.
  output logic [3:0] rPathDelay, // R-path delay code.
  output logic [3:0] nPathDelay, // N-path delay code.
  output logic rPathDelayEn, // R-path delay enable.
  output logic nPathDelayEn // N-path delay enable.
);

  // Bus address phase capture.
  logic wrPending;
  logic [9:0] wrIndex;
  wire addrValid = hsel && htrans[1] && hready;
  wire [9:0] addrIndex = haddr[11:2];

  // Buffered registers written by software, and active copies.
  logic [2:0] calCtlBuf;
  logic [3:0] zdCtlBuf;
  logic thrExtBuf;
  logic [2:0] vcoDivBuf;
  logic [13:0] rDivBuf;
  logic [9:0] zdDlyBuf;
  logic [2:0] calCtlAct;
  logic [3:0] zdCtlAct;
  logic thrExtAct;
  logic [13:0] rDivAct;

  wire wrCalCtl = wrPending && (wrIndex == `VCOZD_IDX_CALCTL);
  wire wrZdCtl = wrPending && (wrIndex == `VCOZD_IDX_ZDCTL);
  wire wrStatus = wrPending && (wrIndex == `VCOZD_IDX_STATUS);
  wire wrVcoDiv = wrPending && (wrIndex == `VCOZD_IDX_VCODIV);
  wire wrRDiv = wrPending && (wrIndex == `VCOZD_IDX_RDIV);
  wire wrZdDly = wrPending && (wrIndex == `VCOZD_IDX_ZDDLY);
  wire updateStrobe = wrPending && (wrIndex == `VCOZD_IDX_UPDATE) &&
                      hwdata[`VCOZD_UPDATE_BIT];

  // Calibration engine state.
  vcozd_pkg::vcozd_cal_state_t calState;
  vcozd_pkg::vcozd_cal_state_t next_calState;
  logic calDone;
  logic calStartPrev;
  logic autoPrev;
  logic [12:0] tuneCount;
  logic calTick;

  wire startRise = calCtlAct[`VCOZD_CAL_START_BIT] && !calStartPrev;
  wire autoRise = autoLoadCal && !autoPrev;
  wire calTrigger = (startRise || autoRise) && (calState == vcozd_pkg::CAL_IDLE);
  wire tuneLast = calTick && (tuneCount == `VCOZD_CAL_CYCLES - 13'h0001);

  // Monitors.
  logic [9:0] monWindow;
  logic [2:0] monPrev;
  logic [7:0] monCount [3];
  wire [2:0] monSrc = {vcoDivided, pllReferenceInput2, pllReferenceInput};
  wire monWindowEnd = (monWindow == `VCOZD_MON_WINDOW);
  wire [7:0] refThr = thrExtAct ? `VCOZD_THR_EXTENDED : `VCOZD_THR_NORMAL;

  // Read mux.
  wire [31:0] statusWord = {25'h0000000, calDone, 2'h0, monitorLow, thrExtBuf};
  logic [31:0] next_hrdata;

  always_comb begin
    case (addrIndex)
      `VCOZD_IDX_CALCTL: next_hrdata = {29'h00000000, calCtlBuf};
      `VCOZD_IDX_ZDCTL: next_hrdata = {27'h0000000, zdCtlBuf, 1'b0};
      `VCOZD_IDX_STATUS: next_hrdata = statusWord;
      `VCOZD_IDX_VCODIV: next_hrdata = {29'h00000000, vcoDivBuf};
      `VCOZD_IDX_RDIV: next_hrdata = {18'h00000, rDivBuf};
      `VCOZD_IDX_ZDDLY: next_hrdata = {22'h000000, zdDlyBuf};
      default: next_hrdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPending <= 1'b0;
      wrIndex <= 10'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPending <= addrValid && hwrite;
      wrIndex <= addrIndex;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrValid && !hwrite) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // Writes land in the buffers; only the update strobe makes them take effect.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      calCtlBuf <= `VCOZD_RST_CALCTL;
      zdCtlBuf <= `VCOZD_RST_ZDCTL;
      thrExtBuf <= 1'b0;
      vcoDivBuf <= `VCOZD_RST_VCODIV;
      rDivBuf <= `VCOZD_RST_RDIV;
      zdDlyBuf <= `VCOZD_RST_ZDDLY;
    end else begin
      if (wrCalCtl) calCtlBuf <= hwdata[2:0];
      if (wrZdCtl) zdCtlBuf <= hwdata[4:1];
      if (wrStatus) thrExtBuf <= hwdata[`VCOZD_THR_EXT_BIT];
      if (wrVcoDiv) vcoDivBuf <= hwdata[2:0];
      if (wrRDiv) rDivBuf <= hwdata[13:0];
      if (wrZdDly) zdDlyBuf <= hwdata[9:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      calCtlAct <= `VCOZD_RST_CALCTL;
      zdCtlAct <= `VCOZD_RST_ZDCTL;
      thrExtAct <= 1'b0;
      rDivAct <= `VCOZD_RST_RDIV;
      vcoDividerSel <= `VCOZD_RST_VCODIV;
      rPathDelay <= 4'h0;
      nPathDelay <= 4'h0;
      rPathDelayEn <= 1'b0;
      nPathDelayEn <= 1'b0;
    end else if (updateStrobe) begin
      calCtlAct <= calCtlBuf;
      zdCtlAct <= zdCtlBuf;
      thrExtAct <= thrExtBuf;
      rDivAct <= rDivBuf;
      vcoDividerSel <= vcoDivBuf;
      rPathDelay <= zdDlyBuf[3:0];
      nPathDelay <= zdDlyBuf[7:4];
      rPathDelayEn <= zdDlyBuf[8];
      nPathDelayEn <= zdDlyBuf[9];
    end
  end

  // Zero delay routing. Reserved mode 10 falls back to normal feedback.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      feedbackSourceSelector <= 2'h0;
      nDividerInputSelector <= 2'h0;
    end else begin
      feedbackSourceSelector <= zdCtlAct[3:2];
      case (zdCtlAct[1:0])
        vcozd_pkg::ZD_INTERNAL: nDividerInputSelector <= vcozd_pkg::ZD_INTERNAL;
        vcozd_pkg::ZD_EXTERNAL: nDividerInputSelector <= vcozd_pkg::ZD_EXTERNAL;
        default: nDividerInputSelector <= vcozd_pkg::ZD_OFF;
      endcase
    end
  end

  // Calibration clock; it only advances on reference edges, so a missing
  // reference stalls the sequence rather than faking a finish.
  vcozd_cal_clk calClk (
    .clock(clock),
    .rst_n(rst_n),
    .pll_reference_input(pllReferenceInput),
    .rDivide(rDivAct),
    .calDivSel(calCtlAct[`VCOZD_CAL_DIV_MSB:`VCOZD_CAL_DIV_LSB]),
    .run(calState == vcozd_pkg::CAL_TUNE),
    .calTick(calTick)
  );

  always_comb begin
    next_calState = calState;
    case (calState)
      vcozd_pkg::CAL_IDLE: if (calTrigger) next_calState = vcozd_pkg::CAL_SYNC;
      vcozd_pkg::CAL_SYNC: next_calState = vcozd_pkg::CAL_TUNE;
      vcozd_pkg::CAL_TUNE: if (tuneLast) next_calState = vcozd_pkg::CAL_RELEASE;
      vcozd_pkg::CAL_RELEASE: next_calState = vcozd_pkg::CAL_CLOSE;
      vcozd_pkg::CAL_CLOSE: next_calState = vcozd_pkg::CAL_IDLE;
      default: next_calState = vcozd_pkg::CAL_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      calState <= vcozd_pkg::CAL_IDLE;
      calStartPrev <= 1'b0;
      autoPrev <= 1'b0;
      tuneCount <= 13'h0000;
      calDone <= 1'b0;
    end else begin
      calState <= next_calState;
      calStartPrev <= calCtlAct[`VCOZD_CAL_START_BIT];
      autoPrev <= autoLoadCal;
      if (calState != vcozd_pkg::CAL_TUNE) begin
        tuneCount <= 13'h0000;
      end else if (calTick) begin
        tuneCount <= tuneCount + 13'h0001;
      end
      if (calTrigger) begin
        calDone <= 1'b0;
      end else if (calState == vcozd_pkg::CAL_CLOSE) begin
        calDone <= 1'b1;
      end
    end
  end

  // Sync covers the whole tuning phase and drops with no settling delay.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncOutputs <= 1'b0;
      vcoTuning <= 1'b0;
      loopClosed <= 1'b1;
    end else begin
      syncOutputs <= (next_calState == vcozd_pkg::CAL_SYNC) ||
                     (next_calState == vcozd_pkg::CAL_TUNE);
      vcoTuning <= (next_calState == vcozd_pkg::CAL_TUNE);
      loopClosed <= (next_calState == vcozd_pkg::CAL_IDLE) ||
                    (next_calState == vcozd_pkg::CAL_CLOSE);
    end
  end

  // Frequency monitors: count edges over a fixed window.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      monWindow <= 10'h000;
      monPrev <= 3'h0;
    end else begin
      monWindow <= monWindowEnd ? 10'h000 : monWindow + 10'h001;
      monPrev <= monSrc;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gMon
      wire [7:0] thr = (gi == 2) ? `VCOZD_THR_VCO : refThr;
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          monCount[gi] <= 8'h00;
          monitorLow[gi] <= 1'b0;
        end else if (monWindowEnd) begin
          monCount[gi] <= 8'h00;
          monitorLow[gi] <= (monCount[gi] < thr);
        end else if (monSrc[gi] && !monPrev[gi] && monCount[gi] != 8'hff) begin
          monCount[gi] <= monCount[gi] + 8'h01;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seqStart;
    calTrigger;
  endsequence

  sequence seqSyncThenTune;
    syncOutputs && !vcoTuning ##1 syncOutputs && vcoTuning;
  endsequence

  AST_START_SYNC: assert property (seqStart |=> seqSyncThenTune)
    else $error("calibration start did not enter sync then tune");

  AST_DONE_CLEAR: assert property (seqStart |=> !calDone)
    else $error("done bit not cleared on new calibration");

  AST_RELEASE_ORDER: assert property (
    (calState == vcozd_pkg::CAL_TUNE) && tuneLast |=> !syncOutputs ##1 loopClosed ##1 calDone)
    else $error("sync release, loop close and done out of order");

  AST_TUNE_LENGTH: assert property (
    (calState == vcozd_pkg::CAL_TUNE) && calTick |-> tuneCount < `VCOZD_CAL_CYCLES)
    else $error("tuning ran past 4400 calibration clocks");

  AST_SYNC_HELD: assert property ((calState == vcozd_pkg::CAL_TUNE) |-> syncOutputs)
    else $error("outputs not held in sync during tuning");

  AST_NO_SELF_START: assert property (
    (calState == vcozd_pkg::CAL_IDLE) && !startRise && !autoRise |=>
      calState == vcozd_pkg::CAL_IDLE)
    else $error("calibration started without a trigger");

  AST_ZD_INTERNAL: assert property (
    zdCtlAct[1:0] == 2'h1 |=> nDividerInputSelector == 2'h1 &&
      feedbackSourceSelector == $past(zdCtlAct[3:2]))
    else $error("internal zero delay routing wrong");

  AST_ZD_EXTERNAL: assert property (zdCtlAct[1:0] == 2'h3 |=> nDividerInputSelector == 2'h3)
    else $error("external zero delay routing wrong");

  AST_MON_FLAG: assert property (
    monWindowEnd && monCount[0] < refThr |=> monitorLow[0])
    else $error("reference monitor missed a low count");

  AST_DONE_READ: assert property (
    addrValid && !hwrite && addrIndex == `VCOZD_IDX_STATUS |=>
      hrdata[`VCOZD_CAL_DONE_BIT] == $past(calDone))
    else $error("done bit readback mismatch");

  AST_UPDATE_LOAD: assert property (updateStrobe |=> calCtlAct == $past(calCtlBuf))
    else $error("update strobe did not transfer calibration control");

endmodule

// *** tb/vcozd_top_tb.sv ***
`timescale 1ns/1ps
`include "vcozd_regs.svh"
module vcozd_top_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic refA = 1'b0;
  logic vcoDiv = 1'b0;
  logic autoLoadCal = 1'b0;
  logic [6:0] refCnt = 7'h00;
  logic refB = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, syncOutputs, vcoTuning, loopClosed, rEn, nEn;
  logic [2:0] monitorLow, vcoDividerSel;
  logic [1:0] fbSel, nSel;
  logic [3:0] rDly, nDly;
  int failures = 0;
  int checked = 0;

  vcozd_top u_vcozd_top (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pllReferenceInput(refA),
    .pllReferenceInput2(refB), .vcoDivided(vcoDiv), .autoLoadCal(autoLoadCal),
    .syncOutputs(syncOutputs), .vcoTuning(vcoTuning), .loopClosed(loopClosed),
    .monitorLow(monitorLow), .feedbackSourceSelector(fbSel), .nDividerInputSelector(nSel),
    .vcoDividerSel(vcoDividerSel), .rPathDelay(rDly), .nPathDelay(nDly),
    .rPathDelayEn(rEn), .nPathDelayEn(nEn)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  // Reference one and the VCO toggle every clock, a 50 MHz rate whose every edge is sampled.
  // Reference two gives eight rising edges per monitor window, between the two thresholds.
  always @(posedge clock) begin
    refCnt <= refCnt + 7'h01;
    refA <= ~refA;
    vcoDiv <= ~vcoDiv;
    refB <= refCnt[6];
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task waitRdy;
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask

  task busWr(input logic [9:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {20'h0, idx, 2'h0};
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask

  task busRd(input logic [9:0] idx, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= {20'h0, idx, 2'h0};
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    waitRdy();
    d = hrdata;
    check(hresp, 1'b0);
  endtask

  // Sel 0 watches the sync hold, 1 the tuning flag, 2 the loop state.
  task waitSig(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? syncOutputs : (sel == 1) ? vcoTuning : loopClosed) !== lvl
           && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (n >= lim) begin
      failures++;
      test_done();
    end
  endtask

  task regsScn;
    logic [31:0] d;
    check(syncOutputs, 1'b0);
    check(loopClosed, 1'b1);
    busRd(`VCOZD_IDX_CALCTL, d);
    check(d, 32'h0);
    busRd(`VCOZD_IDX_ZDCTL, d);
    check(d, 32'h0);
    busRd(`VCOZD_IDX_STATUS, d);
    check(d[6], 1'b0);
    busRd(`VCOZD_IDX_UPDATE, d);
    check(d, 32'h0);
    busRd(10'h3ff, d);
    check(d, 32'h0);
  endtask

  task zdScn;
    for (int i = 0; i < 4; i++) begin
      busWr(`VCOZD_IDX_ZDCTL, {27'h0, i[1:0], i[1:0], 1'b0});
      busWr(`VCOZD_IDX_UPDATE, 32'h1);
      repeat (2) @(posedge clock);
      check(nSel, (i == 2) ? 0 : i);
      check(fbSel, i);
    end
    busWr(`VCOZD_IDX_ZDDLY, 32'h3a5);
    // The VCO divider is only rewritten while no calibration runs.
    busWr(`VCOZD_IDX_VCODIV, 32'h5);
    busWr(`VCOZD_IDX_UPDATE, 32'h1);
    repeat (2) @(posedge clock);
    check({nEn, rEn, nDly, rDly}, 10'h3a5);
    check(vcoDividerSel, 3'h5);
  endtask

  task monScn;
    logic [31:0] d;
    repeat (2100) @(posedge clock);
    check(monitorLow, 3'b010);
    busRd(`VCOZD_IDX_STATUS, d);
    check(d[3:1], 3'b010);
    busWr(`VCOZD_IDX_STATUS, 32'h1);
    busRd(`VCOZD_IDX_STATUS, d);
    check(d[0], 1'b1);
    busWr(`VCOZD_IDX_UPDATE, 32'h1);
    // With the extended threshold, eight edges a window no longer count as low.
    repeat (1100) @(posedge clock);
    check(monitorLow, 3'b000);
  endtask

  task calScn;
    logic [31:0] d;
    int n;
    // R of 5 puts the phase detector at 10 MHz; a divide of 2 then gives 5 MHz.
    busWr(`VCOZD_IDX_RDIV, 32'h5);
    busWr(`VCOZD_IDX_CALCTL, 32'h1);
    repeat (5) @(posedge clock);
    check(syncOutputs, 1'b0);
    busWr(`VCOZD_IDX_UPDATE, 32'h1);
    waitSig(0, 1'b1, 5, n);
    check(loopClosed, 1'b0);
    waitSig(1, 1'b1, 3, n);
    waitSig(1, 1'b0, 90000, n);
    // 4400 ticks of ten reference edges, two clocks per edge, some phase slack.
    check(n >= 87990 && n <= 88010, 1'b1);
    check(syncOutputs, 1'b0);
    waitSig(2, 1'b1, 3, n);
    repeat (2) @(posedge clock);
    busRd(`VCOZD_IDX_STATUS, d);
    check(d[6], 1'b1);
  endtask

  task retrigScn;
    logic [31:0] d;
    int n;
    busWr(`VCOZD_IDX_RDIV, 32'h6);
    busWr(`VCOZD_IDX_UPDATE, 32'h1);
    repeat (5) @(posedge clock);
    check(syncOutputs, 1'b0);
    // A new R value calls for a new calibration through the two-strobe restart.
    busWr(`VCOZD_IDX_CALCTL, 32'h0);
    busWr(`VCOZD_IDX_UPDATE, 32'h1);
    busWr(`VCOZD_IDX_CALCTL, 32'h1);
    busWr(`VCOZD_IDX_UPDATE, 32'h1);
    waitSig(0, 1'b1, 5, n);
    busRd(`VCOZD_IDX_STATUS, d);
    check(d[6], 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check(syncOutputs, 1'b0);
    check(loopClosed, 1'b1);
  endtask

  task autoScn;
    int n;
    autoLoadCal <= 1'b1;
    waitSig(0, 1'b1, 6, n);
    check(loopClosed, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    regsScn();
    zdScn();
    monScn();
    calScn();
    retrigScn();
    autoScn();
    test_done();
  end
endmodule
